// ### rtl/mode_ctl_pkg.sv
package mode_ctl_pkg;

	// ****************************************
	// mode register layout
	// ****************************************
	localparam int unsigned    CFG_W          = 8;
	localparam logic [7:0]     CFG_RESET      = 8'h02;
	localparam int unsigned    MODE_HI        = 7;
	localparam int unsigned    MODE_LO        = 6;
	localparam int unsigned    RANGE_HI       = 5;
	localparam int unsigned    RANGE_LO       = 4;
	localparam int unsigned    BURNOUT_BIT    = 3;
	localparam int unsigned    BUF_BIT        = 1;
	localparam logic [7:0]     CFG_WMASK      = 8'hFA;

	localparam logic [1:0]     MODE_CONT      = 2'h0;
	localparam logic [1:0]     MODE_RSVD      = 2'h1;
	localparam logic [1:0]     MODE_SINGLE    = 2'h2;
	localparam logic [1:0]     MODE_PDOWN     = 2'h3;

	localparam logic [1:0]     RANGE_FULL     = 2'h0;
	localparam logic [1:0]     RANGE_HALF     = 2'h1;
	localparam logic [1:0]     RANGE_QUARTER  = 2'h2;
	localparam logic [1:0]     RANGE_EIGHTH   = 2'h3;

	// ****************************************
	// timing
	// ****************************************
	localparam int unsigned    CLK_HZ         = 40000000;
	localparam int unsigned    RATE_HZ        = 120;
	localparam int unsigned    PERIOD_CYC     = CLK_HZ / RATE_HZ;
	localparam int unsigned    SETTLE_PERIODS = 2;
	localparam int unsigned    DATA_W         = 16;

	// ****************************************
	// carriers
	// ****************************************
	typedef struct packed {
		logic [1:0] mode_select;
		logic [1:0] range_select;
		logic       burnout_enable;
		logic       buffer_enable;
	} cfg_fields_t;

	typedef struct packed {
		logic       buffer_on;
		logic       burnout_on;
		logic       powered;
		logic [3:0] span_onehot;
	} analog_ctl_t;

endpackage : mode_ctl_pkg

// ### rtl/result_store.sv
`timescale 1ns/10ps
`default_nettype none
module result_store
	import mode_ctl_pkg::*;
#(
	parameter int unsigned W = DATA_W
) (
	input  wire logic         i_core_clk,
	input  wire logic         i_rst_b,
	input  wire logic         i_we,
	input  wire logic [W-1:0] i_wdata,
	output logic      [W-1:0] o_rdata
);
	// ****************************************
	// data register, read data from flop
	// ****************************************
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_rdata <= '0;
		end else if (i_we) begin
			o_rdata <= i_wdata;
		end
	end
endmodule : result_store
`default_nettype wire

// ### rtl/adc_mode_control.sv
// Function
// RULE1: top two mode bits: 00 continuous, 01 reserved, 10 single, 11 power-down.
// RULE2: continuous mode converts repeatedly, storing each result unprompted.
// RULE3: ready goes low whenever a finished result is available.
// RULE4: continuous read shifts each new result out on serial clocks.
// RULE5: host may instead fetch results by a read-data command.
// RULE6: continuous: first result after two periods, then one per period.
// RULE7: single: power up, convert in two periods, store, ready low, power down.
// RULE8: single mode stays powered down when not converting.
// RULE9: single result and ready low held until read or new conversion.
// RULE10: range bits pick full, half, quarter or eighth span.
// RULE11: burnout bit switches the 100 nA test sources on or off.
// RULE12: burnout sources active only while the input buffer is on.
// RULE13: buffer bit 1 gives buffered input, 0 unbuffered.
// RULE14: host writes zero to the two unused mode bits.
// RULE15: any mode write resets modulator and filter, ready goes not-ready.
// RULE16: completed data read returns ready to not-ready.
// RULE17: burnout requested without buffer stays disabled.
`timescale 1ns/10ps
`default_nettype none
module adc_mode_control
	import mode_ctl_pkg::*;
#(
	parameter int unsigned PERIOD_CYCLES = PERIOD_CYC
) (
	input  wire logic              i_core_clk,
	input  wire logic              i_rst_b,
	input  wire logic              i_cfg_we,
	input  wire logic [CFG_W-1:0]  i_cfg_wdata,
	input  wire logic              i_cont_read,
	input  wire logic              i_data_read_done,
	input  wire logic              i_sclk_pulse,
	input  wire logic [DATA_W-1:0] i_sample,
	output logic      [CFG_W-1:0]  o_cfg_rdata,
	output logic      [DATA_W-1:0] o_data,
	output logic                   o_ready_b,
	output logic                   o_dout,
	output logic                   o_modulator_reset,
	output analog_ctl_t            o_analog
);
	// ****************************************
	// parameter check
	// ****************************************
	// counter is 24 bits wide; periods shorter than two cycles are rejected
	if (PERIOD_CYCLES < 2 || PERIOD_CYCLES > 32'h00FFFFFF) begin : g_bad_period
		$error("PERIOD_CYCLES out of range");
	end

	typedef enum logic [1:0] {ST_IDLE, ST_SETTLE, ST_RUN} phase_t;

	typedef struct packed {
		logic [CFG_W-1:0] cfg;
		phase_t           phase;
		logic [23:0]      cnt;
		logic [1:0]       periods;
		logic             ready_b;
		logic             mod_rst;
		logic [DATA_W-1:0] shift;
		logic [4:0]       shift_left;
		logic             dout;
	} state_t;

	state_t      s_q;
	state_t      s_d;
	cfg_fields_t f;
	logic        done;
	logic        store_we;
	logic [23:0] last_cnt;

	assign last_cnt = 24'(PERIOD_CYCLES - 1);
	// an aborted result never reaches the data register
	assign store_we = done & ~i_cfg_we; // RULE15

	always_comb begin
		f.mode_select    = s_q.cfg[MODE_HI:MODE_LO];
		f.range_select   = s_q.cfg[RANGE_HI:RANGE_LO];
		f.burnout_enable = s_q.cfg[BURNOUT_BIT];
		f.buffer_enable  = s_q.cfg[BUF_BIT];
	end

	// ****************************************
	// conversion sequencer
	// ****************************************
	always_comb begin
		s_d     = s_q;
		done    = 1'b0;
		s_d.mod_rst = 1'b0;
		if (s_q.phase != ST_IDLE) begin
			s_d.cnt = s_q.cnt + 24'h000001;
			if (s_q.cnt == last_cnt) begin
				s_d.cnt     = '0;
				s_d.periods = s_q.periods + 2'h1;
			end
		end
		case (s_q.phase)
			ST_IDLE: begin
				if (f.mode_select == MODE_CONT) begin // RULE1
					s_d.phase = ST_SETTLE; // RULE2
				end
			end
			ST_SETTLE: begin
				if (s_q.cnt == last_cnt && s_q.periods == 2'(SETTLE_PERIODS - 1)) begin
					done      = 1'b1; // RULE6 RULE7
					s_d.phase = (f.mode_select == MODE_CONT) ? ST_RUN : ST_IDLE; // RULE7 RULE8
				end
			end
			ST_RUN: begin
				if (s_q.cnt == last_cnt) begin
					done = 1'b1; // RULE6
				end
			end
			default: begin
				s_d.phase = ST_IDLE;
			end
		endcase
		if (done) begin
			s_d.ready_b    = 1'b0; // RULE3 RULE9
			s_d.shift      = i_sample;
			s_d.shift_left = i_cont_read ? 5'(DATA_W) : 5'h00;
		end else if (i_data_read_done) begin
			s_d.ready_b = 1'b1; // RULE16
		end
		// continuous read: msb first, one bit per host clock
		if (!done && s_q.shift_left != 5'h00 && i_sclk_pulse) begin
			s_d.dout       = s_q.shift[DATA_W-1]; // RULE4
			s_d.shift      = {s_q.shift[DATA_W-2:0], 1'b0};
			s_d.shift_left = s_q.shift_left - 5'h01;
			if (s_q.shift_left == 5'h01) begin
				s_d.ready_b = 1'b1; // RULE16
			end
		end
		// a write restarts everything; it outranks a coinciding result
		if (i_cfg_we) begin
			s_d.cfg        = i_cfg_wdata & CFG_WMASK; // RULE14
			s_d.mod_rst    = 1'b1; // RULE15
			s_d.ready_b    = 1'b1; // RULE15
			s_d.cnt        = '0;
			s_d.periods    = '0;
			s_d.shift_left = '0;
			case (i_cfg_wdata[MODE_HI:MODE_LO])
				MODE_CONT:   s_d.phase = ST_SETTLE; // RULE1
				MODE_SINGLE: s_d.phase = ST_SETTLE; // RULE7
				default:     s_d.phase = ST_IDLE; // RULE1
			endcase
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			s_q.cfg        <= CFG_RESET;
			s_q.phase      <= ST_SETTLE;
			s_q.cnt        <= '0;
			s_q.periods    <= '0;
			s_q.ready_b    <= 1'b1;
			s_q.mod_rst    <= 1'b1;
			s_q.shift      <= '0;
			s_q.shift_left <= '0;
			s_q.dout       <= 1'b0;
		end else begin
			s_q <= s_d;
		end
	end

	result_store #(
		.W(DATA_W)
	) u_store (
		.i_core_clk(i_core_clk),
		.i_rst_b   (i_rst_b),
		.i_we      (store_we), // RULE2
		.i_wdata   (i_sample),
		.o_rdata   (o_data)
	);

	// ****************************************
	// analog controls
	// ****************************************
	always_comb begin
		o_analog.buffer_on  = f.buffer_enable; // RULE13
		// sources need the buffer to sink their current
		o_analog.burnout_on = f.burnout_enable & f.buffer_enable; // RULE11 RULE12 RULE17
		o_analog.powered    = (s_q.phase != ST_IDLE); // RULE8
		case (f.range_select) // RULE10
			RANGE_FULL:    o_analog.span_onehot = 4'h1;
			RANGE_HALF:    o_analog.span_onehot = 4'h2;
			RANGE_QUARTER: o_analog.span_onehot = 4'h4;
			RANGE_EIGHTH:  o_analog.span_onehot = 4'h8;
			default:       o_analog.span_onehot = 4'h1;
		endcase
	end

	assign o_cfg_rdata       = s_q.cfg;
	assign o_ready_b         = s_q.ready_b;
	assign o_dout            = s_q.dout;
	assign o_modulator_reset = s_q.mod_rst;

endmodule : adc_mode_control
`default_nettype wire

// ### verif/adc_mode_control_checker.sv
`timescale 1ns/10ps
`default_nettype none
// *****
// mode checks
// *****
module adc_mode_control_checker
	import mode_ctl_pkg::*;
#(
	parameter int unsigned PERIOD_CYCLES = PERIOD_CYC
) (
	input wire logic        i_core_clk,
	input wire logic        i_rst_b,
	input wire logic        i_cfg_we,
	input wire logic [15:0] i_sample,
	input wire logic [7:0]  o_cfg_rdata,
	input wire logic [15:0] o_data,
	input wire logic        o_ready_b,
	input wire logic        o_modulator_reset,
	input wire analog_ctl_t o_analog
);
	localparam int SETTLE = 2 * PERIOD_CYCLES;
	logic [23:0] since_q;
	logic [23:0] since_d;
	logic [1:0]  md;
	assign md = o_cfg_rdata[7:6];
	// saturates, so a stale write never looks fresh
	assign since_d = i_cfg_we ? 24'h000000 : since_q + 24'(since_q != 24'hFFFFFF);
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b)
			since_q <= 24'hFFFFFF;
		else
			since_q <= since_d;
	end
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_b);
	sequence s_settled;
		since_q == SETTLE - 1 && !md[0] && !i_cfg_we;
	endsequence
	AST_WR: assert property (i_cfg_we |=> o_ready_b && o_modulator_reset)
		else $error("write did not restart");
	AST_FIRST: assert property (s_settled |=> $fell(o_ready_b))
		else $error("first result late or early");
	AST_NEXT: assert property (
		since_q == SETTLE + PERIOD_CYCLES - 1 && md == MODE_CONT && !i_cfg_we
		|=> !o_ready_b && o_data == $past(i_sample)) else $error("no periodic result");
	AST_DATA: assert property ($fell(o_ready_b) |-> o_data == $past(i_sample))
		else $error("ready without result");
	AST_SGL_OFF: assert property (md == MODE_SINGLE && since_q >= SETTLE |-> !o_analog.powered)
		else $error("single mode left powered");
	AST_IDLE: assert property (md[0] |-> !o_analog.powered && o_ready_b)
		else $error("idle mode active");
	AST_BURN: assert property (o_analog.burnout_on == (o_cfg_rdata[3] && o_cfg_rdata[1]))
		else $error("burnout wrong");
	AST_SPAN: assert property (o_analog.buffer_on == o_cfg_rdata[1]
		&& o_analog.span_onehot == 4'h1 << o_cfg_rdata[5:4]) else $error("span or buffer wrong");
endmodule : adc_mode_control_checker
bind adc_mode_control adc_mode_control_checker #(.PERIOD_CYCLES(PERIOD_CYCLES)) u_check (
	.i_core_clk(i_core_clk),
	.i_rst_b(i_rst_b),
	.i_cfg_we(i_cfg_we),
	.i_sample(i_sample),
	.o_cfg_rdata(o_cfg_rdata),
	.o_data(o_data),
	.o_ready_b(o_ready_b),
	.o_modulator_reset(o_modulator_reset),
	.o_analog(o_analog)
);
`default_nettype wire

// ### verif/host_model.sv
`timescale 1ns/10ps
`default_nettype none
// *****
// host side
// *****
module host_model (
	input  wire logic  i_core_clk,
	input  wire logic  i_ready_b,
	input  wire logic  i_fetch,
	input  wire logic  i_stream,
	input  wire logic  i_dout,
	output logic       o_read_done,
	output logic       o_sclk_pulse,
	output logic [15:0] o_word
);
	initial begin
		o_read_done = 1'b0;
		o_sclk_pulse = 1'b0;
		o_word = 16'h0;
		forever begin
			@(negedge i_core_clk);
			if (i_fetch && !i_ready_b) begin
				o_read_done = 1'b1;
				@(negedge i_core_clk);
				o_read_done = 1'b0;
			end
			if (i_stream && !i_ready_b) begin
				o_sclk_pulse = 1'b1;
				repeat (16) begin
					@(negedge i_core_clk);
					o_word = {o_word[14:0], i_dout};
				end
				o_sclk_pulse = 1'b0;
			end
		end
	end
endmodule : host_model
`default_nettype wire

// ### verif/adc_mode_control_bench.sv
`timescale 1ns/10ps
`default_nettype none
// *****
// bench
// *****
module adc_mode_control_bench
	import mode_ctl_pkg::*;
;
	localparam int P = 20;
	logic clk, rst_b, we, cont, done, sclk, fetch, stream, dout, rdy_b, mrst;
	logic [7:0] wd, cfg;
	logic [15:0] smp, dat, word;
	analog_ctl_t ana;
	int miscompares, total_checks, k;
	adc_mode_control #(.PERIOD_CYCLES(P)) DUT (.i_core_clk(clk), .i_rst_b(rst_b),
		.i_cfg_we(we), .i_cfg_wdata(wd), .i_cont_read(cont), .i_data_read_done(done),
		.i_sclk_pulse(sclk), .i_sample(smp), .o_cfg_rdata(cfg), .o_data(dat),
		.o_ready_b(rdy_b), .o_dout(dout), .o_modulator_reset(mrst), .o_analog(ana));
	host_model u_host (.i_core_clk(clk), .i_ready_b(rdy_b), .i_fetch(fetch), .i_stream(stream),
		.i_dout(dout), .o_read_done(done), .o_sclk_pulse(sclk), .o_word(word));
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic results();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : results
	task automatic wr(input logic [7:0] v);
		@(negedge clk);
		we = 1'b1;
		wd = v;
		@(negedge clk);
		we = 1'b0;
	endtask : wr
	// k ends as the cycles taken
	task automatic wait_rdy(input logic lvl);
		k = 0;
		while (rdy_b !== lvl && k < 200) begin
			@(negedge clk);
			k++;
		end
		if (k >= 200) begin
			miscompares++;
			results();
		end
	endtask : wait_rdy
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	initial begin
		{rst_b, we, wd, cont, fetch, stream, smp} = '0;
		repeat (10) @(negedge clk);
		rst_b = 1'b1;
		check("cfg reset", cfg, 16'h02);
		for (int g = 0; g < 4; g++) begin
			wr({2'h3, 2'(g), 4'hA});
			check("span", ana.span_onehot, 16'h1 << g);
			check("burnout", ana.burnout_on, 1'b1);
			check("pdown", ana.powered, 1'b0);
		end
		wr(8'h4F);
		check("cfg rsvd", cfg, 16'h4A);
		wr(8'hC8);
		check("no buf burnout", ana.burnout_on, 1'b0);
		check("unbuffered", ana.buffer_on, 1'b0);
		$display("config done");
		smp = 16'hB00F;
		wr(8'h82);
		check("powered up", ana.powered, 1'b1);
		wait_rdy(1'b0);
		check("single time", 16'(k), 16'(2 * P));
		check("single data", dat, 16'hB00F);
		smp = 16'h0FF0;
		repeat (30) @(negedge clk);
		check("single held", {dat[14:0], rdy_b}, 16'h601E);
		check("single off", ana.powered, 1'b0);
		// host samples on falling edges, so set its request away from them
		@(posedge clk);
		fetch = 1'b1;
		@(negedge clk);
		wait_rdy(1'b1);
		fetch = 1'b0;
		check("read clears", 16'(k), 16'h1);
		$display("single done");
		smp = 16'h6A53;
		{cont, stream} = 2'h3;
		wr(8'h02);
		wait_rdy(1'b0);
		check("first", 16'(k), 16'(2 * P));
		wait_rdy(1'b1);
		check("shift len", 16'(k), 16'(DATA_W));
		stream = 1'b0;
		smp = 16'h1234;
		wait_rdy(1'b0);
		check("period", 16'(k), 16'(P - 16));
		// host takes its last bit on the edge where the shift wait ends
		check("stream", word, 16'h6A53);
		check("cont data", dat, 16'h1234);
		wr(8'hC2);
		check("write unready", rdy_b, 1'b1);
		check("mod reset", mrst, 1'b1);
		$display("continuous done");
		results();
	end
endmodule : adc_mode_control_bench
`default_nettype wire
